/* attr_regs_pkg.sv */
`default_nettype none
package attr_regs_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_MAIN  = 12'h060;
  localparam logic [11:0] OFF_IFACE = 12'h064;
  localparam logic [11:0] OFF_WAKE  = 12'h068;
  localparam logic [11:0] OFF_SCR0  = 12'h06C;
  localparam logic [11:0] OFF_SCR1  = 12'h070;
  localparam logic [11:0] OFF_SCR2  = 12'h074;
  localparam int          SCR_N     = 3;

  // ----------------------------------------------------------------
  // Field layout inside the main string and wake registers
  // ----------------------------------------------------------------
  localparam int LEN_W     = 8;
  localparam int CFG_LSB   = 24;
  localparam int SER_LSB   = 16;
  localparam int PROD_LSB  = 8;
  localparam int MAKER_LSB = 0;
  localparam int WAKE_W    = 16;
  localparam int WAKE_HI   = 8;

  // ----------------------------------------------------------------
  // Image layout: main word, interface length, wake flags
  // ----------------------------------------------------------------
  localparam int IMG_W         = 56;
  localparam int IMG_MAIN_LSB  = 0;
  localparam int IMG_IFACE_LSB = 32;
  localparam int IMG_WAKE_LSB  = 40;

  // Reset values and responses
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Register select
  typedef enum logic [2:0] {
    REG_MAIN, REG_IFACE, REG_WAKE, REG_SCR0, REG_SCR1, REG_SCR2,
    REG_NONE
  } reg_sel_t;

  // Map a byte address onto a register
  function automatic reg_sel_t decode_reg(input logic [11:0] a);
    case (a)
      OFF_MAIN:  return REG_MAIN;
      OFF_IFACE: return REG_IFACE;
      OFF_WAKE:  return REG_WAKE;
      OFF_SCR0:  return REG_SCR0;
      OFF_SCR1:  return REG_SCR1;
      OFF_SCR2:  return REG_SCR2;
      default:   return REG_NONE;
    endcase
  endfunction : decode_reg

  // Replace the bytes selected by the strobes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : merge_bytes
endpackage : attr_regs_pkg
`default_nettype wire

/* axil_port.sv */
`timescale 1ns/1ns
`default_nettype none
module axil_port
  import attr_regs_pkg::*;
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [attr_regs_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                         awvalid,
  output var  logic                         awready,
  input  wire logic [attr_regs_pkg::DATA_W-1:0] wdata,
  input  wire logic [attr_regs_pkg::STRB_W-1:0] wstrb,
  input  wire logic                         wvalid,
  output var  logic                         wready,
  output var  logic [1:0]                   bresp,
  output var  logic                         bvalid,
  input  wire logic                         bready,
  input  wire logic [attr_regs_pkg::ADDR_W-1:0] araddr,
  input  wire logic                         arvalid,
  output var  logic                         arready,
  output var  logic [attr_regs_pkg::DATA_W-1:0] rdata,
  output var  logic [1:0]                   rresp,
  output var  logic                         rvalid,
  input  wire logic                         rready,
  output var  logic                         wr_en,
  output var  logic [attr_regs_pkg::ADDR_W-1:0] wr_addr,
  output var  logic [attr_regs_pkg::DATA_W-1:0] wr_data,
  output var  logic [attr_regs_pkg::STRB_W-1:0] wr_strb,
  input  wire logic                         wr_err,
  output var  logic                         rd_en,
  input  wire logic [attr_regs_pkg::DATA_W-1:0] rd_data,
  input  wire logic                         rd_err
);
  // ----------------------------------------------------------------
  // Channel state: a low ready means that channel's slot is full
  // ----------------------------------------------------------------
  logic              next_awready, next_wready, next_arready;
  logic              next_bvalid, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [DATA_W-1:0] next_wr_data, next_rdata;
  logic [STRB_W-1:0] next_wr_strb;

  // Write fires once both halves are held and no answer is pending
  assign wr_en = !awready && !wready && !bvalid;
  // Read is taken at the address handshake
  assign rd_en = arvalid && arready;

  // Next values of all channel flops
  always_comb begin
    next_awready = awready;
    next_wready  = wready;
    next_arready = arready;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    // Capture address and data in either order
    if (awvalid && awready) begin
      next_awready = 1'b0;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_wready  = 1'b0;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    // Answer the write, unmapped gets an error
    if (wr_en) begin
      next_bvalid = 1'b1;
      next_bresp  = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    // Response taken: free both slots
    if (bvalid && bready) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    // Read answered one cycle after the address
    if (rd_en) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = rd_err ? ZERO_WORD : rd_data;
      next_rresp   = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (rvalid && rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  // Register the channel state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      arready <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= ZERO_WORD;
      wr_addr <= '0;
      wr_data <= ZERO_WORD;
      wr_strb <= '0;
    end else begin
      awready <= next_awready;
      wready  <= next_wready;
      arready <= next_arready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
    end
  end
endmodule : axil_port
`default_nettype wire

/* descriptor_attribute_registers.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// [R01] Defaults from EEPROM, else OTP, else zero
// [R02] Bus or lite reset restores loaded image
// [R03] Software zeroes sizes of absent strings
// [R04] Sizes apply only in emulation without sources
// [R05] Software avoids writes when sources exist
// [R06] Reset protection shields all these registers
// [R07] Main register: config, serial, product, maker
// [R08] Interface length in low byte only
// [R09] Wake flags: high byte, low byte
// [R10] Three zero-reset scratch words from 06Ch
// [R11] Reserved bits read zero, ignore writes
module descriptor_attribute_registers
  import attr_regs_pkg::*;
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [attr_regs_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                         awvalid,
  output var  logic                         awready,
  input  wire logic [attr_regs_pkg::DATA_W-1:0] wdata,
  input  wire logic [attr_regs_pkg::STRB_W-1:0] wstrb,
  input  wire logic                         wvalid,
  output var  logic                         wready,
  output var  logic [1:0]                   bresp,
  output var  logic                         bvalid,
  input  wire logic                         bready,
  input  wire logic [attr_regs_pkg::ADDR_W-1:0] araddr,
  input  wire logic                         arvalid,
  output var  logic                         arready,
  output var  logic [attr_regs_pkg::DATA_W-1:0] rdata,
  output var  logic [1:0]                   rresp,
  output var  logic                         rvalid,
  input  wire logic                         rready,
  input  wire logic                         eeprom_present,
  input  wire logic                         eeprom_image_load,
  input  wire logic [attr_regs_pkg::IMG_W-1:0] eeprom_image,
  input  wire logic                         otp_configured,
  input  wire logic                         otp_image_load,
  input  wire logic [attr_regs_pkg::IMG_W-1:0] otp_image,
  input  wire logic                         usb_bus_reset,
  input  wire logic                         lite_soft_reset,
  input  wire logic                         reset_protect,
  input  wire logic                         descriptor_emulation_enable,
  output var  logic                         emulation_active,
  output var  logic [attr_regs_pkg::LEN_W-1:0] config_string_len,
  output var  logic [attr_regs_pkg::LEN_W-1:0] serial_string_len,
  output var  logic [attr_regs_pkg::LEN_W-1:0] product_string_len,
  output var  logic [attr_regs_pkg::LEN_W-1:0] maker_string_len,
  output var  logic [attr_regs_pkg::LEN_W-1:0] interface_string_len,
  output var  logic [attr_regs_pkg::LEN_W-1:0] wake_event_flags_high,
  output var  logic [attr_regs_pkg::LEN_W-1:0] wake_event_flags_low
);
  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  logic              wr_en;     // Write strobe, one cycle
  logic [ADDR_W-1:0] wr_addr;   // Held write address
  logic [DATA_W-1:0] wr_data;   // Held write data
  logic [STRB_W-1:0] wr_strb;   // Held byte enables
  logic              wr_err;    // Write hits no register
  logic              rd_en;     // Read strobe at address handshake
  logic [DATA_W-1:0] rd_data;   // Read word for the address
  logic              rd_err;    // Read hits no register
  reg_sel_t          wr_sel;    // Decoded write target
  reg_sel_t          rd_sel;    // Decoded read target

  axil_port u_port (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_en   (rd_en),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  assign wr_sel = decode_reg(wr_addr);
  assign rd_sel = decode_reg(araddr);
  assign wr_err = (wr_sel == REG_NONE);
  assign rd_err = (rd_sel == REG_NONE);

  // ----------------------------------------------------------------
  // Stored image and live attribute registers
  // ----------------------------------------------------------------
  logic [IMG_W-1:0]  img, next_img;          // Last loaded image
  logic [31:0]       attr_main, next_main;   // Four string lengths
  logic [LEN_W-1:0]  iface_len, next_iface;  // Interface length
  logic [WAKE_W-1:0] wake, next_wake;        // Wake flag bytes
  logic [31:0]       scratch [SCR_N];        // Host scratch words
  logic [31:0]       next_scratch [SCR_N];
  logic              load_now;               // New image this cycle
  logic              revert;                 // Restore from image
  logic [31:0]       wr_iface_w, wr_wake_w;  // Merged narrow writes

  // [R01] Source priority on load
  assign load_now = eeprom_image_load ||
                    (otp_image_load && !eeprom_present);
  // [R02] [R06] Revert unless protected
  assign revert = (usb_bus_reset || lite_soft_reset) && !reset_protect;

  // [R11] Narrow registers keep only their live bits
  assign wr_iface_w = merge_bytes({24'h00_0000, iface_len}, wr_data,
                                  wr_strb);
  assign wr_wake_w  = merge_bytes({16'h0000, wake}, wr_data, wr_strb);

  // Next image and register values
  always_comb begin
    next_img   = img;
    next_main  = attr_main;
    next_iface = iface_len;
    next_wake  = wake;
    for (int i = 0; i < SCR_N; i++) next_scratch[i] = scratch[i];
    // [R01] EEPROM wins, then OTP, else zero
    if (eeprom_image_load) begin
      next_img = eeprom_image;
    end else if (otp_image_load && !eeprom_present) begin
      next_img = otp_configured ? otp_image : '0;
    end
    if (load_now) begin
      // New defaults go live at once
      next_main  = next_img[IMG_MAIN_LSB +: 32];
      next_iface = next_img[IMG_IFACE_LSB +: LEN_W];
      next_wake  = next_img[IMG_WAKE_LSB +: WAKE_W];
    end else if (revert) begin
      // [R02] Restore last image
      next_main  = img[IMG_MAIN_LSB +: 32];
      next_iface = img[IMG_IFACE_LSB +: LEN_W];
      next_wake  = img[IMG_WAKE_LSB +: WAKE_W];
    end else if (wr_en) begin
      // [R07] [R08] [R09] Byte-lane writes
      case (wr_sel)
        REG_MAIN:  next_main  = merge_bytes(attr_main, wr_data, wr_strb);
        REG_IFACE: next_iface = wr_iface_w[LEN_W-1:0];
        REG_WAKE:  next_wake  = wr_wake_w[WAKE_W-1:0];
        default:   next_main  = attr_main;
      endcase
    end
    // [R10] Scratch words clear on unprotected reset only
    for (int i = 0; i < SCR_N; i++) begin
      if (revert) begin
        next_scratch[i] = ZERO_WORD;
      end else if (wr_en && (wr_sel == reg_sel_t'(REG_SCR0 + i))) begin
        next_scratch[i] = merge_bytes(scratch[i], wr_data, wr_strb);
      end
    end
  end

  // Register image and attributes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      img       <= '0;
      attr_main <= ZERO_WORD;
      iface_len <= '0;
      wake      <= '0;
      for (int i = 0; i < SCR_N; i++) scratch[i] <= ZERO_WORD;
    end else begin
      img       <= next_img;
      attr_main <= next_main;
      iface_len <= next_iface;
      wake      <= next_wake;
      for (int i = 0; i < SCR_N; i++) scratch[i] <= next_scratch[i];
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // [R11] Reserved bits read as zero
  always_comb begin
    case (rd_sel)
      REG_MAIN:  rd_data = attr_main;
      REG_IFACE: rd_data = {24'h00_0000, iface_len};
      REG_WAKE:  rd_data = {16'h0000, wake};
      REG_SCR0:  rd_data = scratch[0];
      REG_SCR1:  rd_data = scratch[1];
      REG_SCR2:  rd_data = scratch[2];
      default:   rd_data = ZERO_WORD;
    endcase
  end

  // ----------------------------------------------------------------
  // Effective values toward descriptor handling
  // ----------------------------------------------------------------
  logic emu;                  // Registers steer the descriptors
  logic [31:0]       src_main;
  logic [LEN_W-1:0]  src_iface;
  logic [WAKE_W-1:0] src_wake;

  // [R04] Emulation only without EEPROM or OTP
  assign emu = !eeprom_present && !otp_configured &&
               descriptor_emulation_enable;

  // Select live registers or loaded image
  always_comb begin
    if (emu) begin
      src_main  = attr_main;
      src_iface = iface_len;
      src_wake  = wake;
    end else begin
      src_main  = img[IMG_MAIN_LSB +: 32];
      src_iface = img[IMG_IFACE_LSB +: LEN_W];
      src_wake  = img[IMG_WAKE_LSB +: WAKE_W];
    end
  end

  // Register the outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emulation_active      <= 1'b0;
      config_string_len     <= '0;
      serial_string_len     <= '0;
      product_string_len    <= '0;
      maker_string_len      <= '0;
      interface_string_len  <= '0;
      wake_event_flags_high <= '0;
      wake_event_flags_low  <= '0;
    end else begin
      emulation_active      <= emu;
      config_string_len     <= src_main[CFG_LSB +: LEN_W];
      serial_string_len     <= src_main[SER_LSB +: LEN_W];
      product_string_len    <= src_main[PROD_LSB +: LEN_W];
      maker_string_len      <= src_main[MAKER_LSB +: LEN_W];
      interface_string_len  <= src_iface;
      wake_event_flags_high <= src_wake[WAKE_HI +: LEN_W];
      wake_event_flags_low  <= src_wake[0 +: LEN_W];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_EEPROM_LOAD: assert property ( // [R01]
    eeprom_image_load |=> attr_main == $past(eeprom_image[31:0]))
    else $error("EEPROM image not loaded");

  AST_OTP_BLANK: assert property ( // [R01]
    otp_image_load && !eeprom_present && !otp_configured &&
    !eeprom_image_load |=> attr_main == ZERO_WORD && wake == '0)
    else $error("Unconfigured OTP did not give zero");

  AST_REVERT: assert property ( // [R02]
    revert && !load_now |=> attr_main == $past(img[31:0]) &&
    iface_len == $past(img[IMG_IFACE_LSB +: LEN_W]))
    else $error("Reset did not restore image");

  AST_PROTECT: assert property ( // [R06]
    (usb_bus_reset || lite_soft_reset) && reset_protect &&
    !load_now && !wr_en |=> $stable(attr_main) && $stable(scratch[0]))
    else $error("Protected register disturbed");

  AST_EMU_SRC: assert property ( // [R04]
    emu |=> emulation_active &&
    config_string_len == $past(attr_main[CFG_LSB +: LEN_W]))
    else $error("Emulation output not from register");

  AST_IMG_SRC: assert property ( // [R04]
    !emu |=> !emulation_active &&
    maker_string_len == $past(img[MAKER_LSB +: LEN_W]))
    else $error("Non-emulation output not from image");

  AST_MAIN_ORDER: assert property ( // [R07]
    wr_en && wr_sel == REG_MAIN && wr_strb == 4'hF && !load_now &&
    !revert ##1 emu |=> product_string_len == $past(wr_data[15:8], 2))
    else $error("String length field order wrong");

  AST_IFACE_RSV: assert property ( // [R08]
    rd_en && rd_sel == REG_IFACE |-> rd_data[31:8] == 24'h00_0000)
    else $error("Interface register upper bits not zero");

  AST_WAKE_WR: assert property ( // [R09]
    wr_en && wr_sel == REG_WAKE && wr_strb == 4'hF && !load_now &&
    !revert |=> wake == $past(wr_data[15:0]))
    else $error("Wake flag write lost");

  AST_SCR_ZERO: assert property ( // [R10]
    $rose(aresetn) |-> scratch[0] == ZERO_WORD &&
    scratch[1] == ZERO_WORD && scratch[2] == ZERO_WORD)
    else $error("Scratch not zero after reset");

  AST_RSV_READ: assert property ( // [R11]
    rvalid && $past(rd_en && rd_sel == REG_WAKE) |->
    rdata[31:16] == 16'h0000)
    else $error("Reserved wake bits read nonzero");

  COV_EEPROM: cover property (eeprom_image_load ##1 revert);
  COV_EMU_WR: cover property (emu && wr_en && wr_sel == REG_MAIN);
  COV_SCR_RD: cover property (rd_en && rd_sel == REG_SCR2);
  COV_BAD:    cover property (wr_en && wr_err);
endmodule : descriptor_attribute_registers
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import attr_regs_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, emu;
  logic        eep = 1'h0, eep_ld = 1'h0, otp = 1'h0, otp_ld = 1'h0;
  logic        usb_rst = 1'h0, lite_rst = 1'h0, prot = 1'h0, emu_en = 1'h0;
  logic [55:0] eep_img = 56'h6F_705E_A1B2_C3D4;
  logic [55:0] otp_img = 56'h11_2233_4455_6677;
  logic [7:0]  cfg, ser, prod, mkr, ifc, wk_hi, wk_lo;
  int          failures = 0, checked = 0, cycles = 0;
  logic [31:0] d;
  logic [1:0]  r;

  // Clock at 50 MHz and hang guard
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end

  descriptor_attribute_registers DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .eeprom_present(eep), .eeprom_image_load(eep_ld),
    .eeprom_image(eep_img), .otp_configured(otp),
    .otp_image_load(otp_ld), .otp_image(otp_img),
    .usb_bus_reset(usb_rst), .lite_soft_reset(lite_rst),
    .reset_protect(prot), .descriptor_emulation_enable(emu_en),
    .emulation_active(emu), .config_string_len(cfg),
    .serial_string_len(ser), .product_string_len(prod),
    .maker_string_len(mkr), .interface_string_len(ifc),
    .wake_event_flags_high(wk_hi), .wake_event_flags_low(wk_lo)
  );

  // ----------------------------------------------------------------
  // Bus tasks: handshakes judged at the falling edge before each rise
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [3:0] s, output logic [1:0] rs);
    logic ta, tw, hb;
    ta = 1'h0;
    tw = 1'h0;
    hb = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!hb) begin
      @(negedge aclk);
      ta = ta | (awvalid & awready);
      tw = tw | (wvalid & wready);
      hb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (hb) bready <= 1'h0;
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    logic ta, hr;
    hr = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!hr) begin
      @(negedge aclk);
      ta = arvalid & arready;
      hr = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      if (hr) rready <= 1'h0;
    end
  endtask : rd

  // ----------------------------------------------------------------
  // Compare tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk_word

  task automatic chk_resp(input string n, input logic [1:0] e,
                          input logic [1:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk_resp

  // Read a register, expect the word and an OKAY answer
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk_word($sformatf("rdata at %h", a), e, d);
    chk_resp($sformatf("rresp at %h", a), RESP_OKAY, r);
  endtask : rd_chk

  // Write a register and expect the given answer
  task automatic wr_chk(input logic [11:0] a, input logic [31:0] v,
                        input logic [3:0] s, input logic [1:0] e);
    wr(a, v, s, r);
    chk_resp($sformatf("bresp at %h", a), e, r);
  endtask : wr_chk

  // Effective outputs, given time to follow the registers
  task automatic chk_out(input logic [31:0] m, input logic [7:0] i,
                         input logic [15:0] w, input logic a);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk_word("length outputs", m, {cfg, ser, prod, mkr});
    chk_word("interface length", {24'h0, i}, {24'h0, ifc});
    chk_word("wake outputs", {16'h0, w}, {16'h0, wk_hi, wk_lo});
    chk_word("emulation active", {31'h0, a}, {31'h0, emu});
    // Hand back on a rising edge so callers drive there
    @(posedge aclk);
  endtask : chk_out

  // One-cycle pulse: 0 bus reset, 1 lite reset, 2 eeprom, 3 otp load
  task automatic pulse(input int k);
    @(posedge aclk);
    case (k)
      0: usb_rst <= 1'h1;
      1: lite_rst <= 1'h1;
      2: eep_ld <= 1'h1;
      default: otp_ld <= 1'h1;
    endcase
    @(posedge aclk);
    usb_rst <= 1'h0;
    lite_rst <= 1'h0;
    eep_ld <= 1'h0;
    otp_ld <= 1'h0;
  endtask : pulse

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    // Reset values and unmapped place
    for (int i = 0; i < 6; i++) begin
      rd_chk(12'h060 + 12'(4 * i), ZERO_WORD);
    end
    rd(12'h078, d, r);
    chk_resp("unmapped rresp", RESP_SLVERR, r);
    chk_word("unmapped rdata", ZERO_WORD, d);
    $display("test reset done");
    // Field layout, byte strobes, reserved bits, scratch words
    wr_chk(OFF_MAIN, 32'h1122_3344, 4'hF, RESP_OKAY);
    wr_chk(OFF_MAIN, 32'hFFFF_AAFF, 4'h2, RESP_OKAY);
    rd_chk(OFF_MAIN, 32'h1122_AA44);
    wr_chk(OFF_IFACE, 32'hFFFF_FF5A, 4'hF, RESP_OKAY);
    rd_chk(OFF_IFACE, 32'h0000_005A);
    wr_chk(OFF_WAKE, 32'hFFFF_1234, 4'hF, RESP_OKAY);
    rd_chk(OFF_WAKE, 32'h0000_1234);
    for (int i = 0; i < 12; i += 4) begin
      wr_chk(OFF_SCR0 + 12'(i), 32'hC0DE_0000 + i, 4'hF, RESP_OKAY);
    end
    for (int i = 0; i < 12; i += 4) begin
      rd_chk(OFF_SCR0 + 12'(i), 32'hC0DE_0000 + i);
    end
    wr_chk(12'h078, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    rd_chk(OFF_SCR2, 32'hC0DE_0008);
    $display("test fields done");
    // Live registers drive outputs only in emulation
    emu_en <= 1'h1;
    chk_out(32'h1122_AA44, 8'h5A, 16'h1234, 1'h1);
    emu_en <= 1'h0;
    chk_out(ZERO_WORD, 8'h00, 16'h0000, 1'h0);
    $display("test emulation done");
    // Image sources: OTP, then EEPROM over it, OTP then refused
    otp <= 1'h1;
    pulse(3);
    rd_chk(OFF_MAIN, 32'h4455_6677);
    eep <= 1'h1;
    pulse(2);
    pulse(3);
    rd_chk(OFF_MAIN, 32'hA1B2_C3D4);
    rd_chk(OFF_IFACE, 32'h0000_005E);
    rd_chk(OFF_WAKE, 32'h0000_6F70);
    emu_en <= 1'h1;
    chk_out(32'hA1B2_C3D4, 8'h5E, 16'h6F70, 1'h0);
    $display("test image done");
    // Bus and lite reset revert, reset protection holds
    // Writes only once both image sources are gone
    eep <= 1'h0;
    otp <= 1'h0;
    wr_chk(OFF_MAIN, 32'h0102_0304, 4'hF, RESP_OKAY);
    wr_chk(OFF_IFACE, ZERO_WORD, 4'hF, RESP_OKAY);
    wr_chk(OFF_SCR0, 32'h5555_AAAA, 4'hF, RESP_OKAY);
    pulse(0);
    rd_chk(OFF_MAIN, 32'hA1B2_C3D4);
    rd_chk(OFF_IFACE, 32'h0000_005E);
    rd_chk(OFF_SCR0, ZERO_WORD);
    wr_chk(OFF_MAIN, 32'h0102_0304, 4'hF, RESP_OKAY);
    wr_chk(OFF_SCR0, 32'h5555_AAAA, 4'hF, RESP_OKAY);
    prot <= 1'h1;
    pulse(1);
    rd_chk(OFF_MAIN, 32'h0102_0304);
    rd_chk(OFF_SCR0, 32'h5555_AAAA);
    prot <= 1'h0;
    pulse(1);
    rd_chk(OFF_MAIN, 32'hA1B2_C3D4);
    chk_out(32'hA1B2_C3D4, 8'h5E, 16'h6F70, 1'h1);
    $display("test revert done");
    test_done();
  end
endmodule : tb
`default_nettype wire
